// [ed_timer_pkg.sv]
package ed_timer_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [12:0] CTRL_A_IDX   = 13'h1fc0;
  localparam logic [12:0] CTRL_B_IDX   = 13'h1fc1;
  localparam logic [12:0] PERIOD_IDX   = 13'h1fc2;
  localparam logic [12:0] ANGLE_IDX    = 13'h1fc3;
  localparam logic [12:0] AMP_IDX      = 13'h1fc4;
  localparam logic [12:0] CAPTURE_IDX  = 13'h1fc5;
  localparam logic [12:0] SINE_WR_IDX  = 13'h1fc6;
  localparam logic [12:0] CMP_U_IDX    = 13'h1fc7;
  localparam logic [12:0] CMP_V_IDX    = 13'h1fc8;
  localparam logic [12:0] CMP_W_IDX    = 13'h1fc9;

  // angle_timer_control fields
  localparam int unsigned DIR_BIT      = 7;
  localparam int unsigned ORDER_BIT    = 6;
  localparam int unsigned TCK_LSB      = 4;
  localparam int unsigned MOD3_BIT     = 3;
  localparam int unsigned XFER_BIT     = 2;
  localparam int unsigned CALC_EN_BIT  = 1;
  localparam int unsigned TMR_EN_BIT   = 0;
  localparam logic [7:0]  CTRL_A_RESET = 8'h00;

  // calculation_control fields
  localparam int unsigned KICK_BIT     = 3;
  localparam int unsigned BUSY_BIT     = 2;
  localparam int unsigned SYNC_BIT     = 1;
  localparam int unsigned IRQSEL_BIT   = 0;

  // angle_period_setting fields
  localparam int unsigned CORR_LSB     = 12;
  localparam int unsigned BASE_MSB     = 11;
  localparam logic [15:0] PERIOD_RESET = 16'h0010;
  localparam logic [11:0] BASE_MIN     = 12'h010;

  // Angle geometry: 384 steps per electrical period
  localparam logic [8:0]  ANGLE_MAX    = 9'h17f;
  localparam logic [9:0]  ANGLE_STEPS  = 10'h180;
  localparam logic [9:0]  DEG_120      = 10'h080;
  localparam logic [9:0]  DEG_240      = 10'h100;
  localparam logic [8:0]  DEG_180      = 9'h0c0;
  localparam logic [4:0]  CORR_GROUP   = 5'h10;

  // Prescaler masks for fc/8, fc/16, fc/32, fc/64
  localparam logic [5:0]  DIV8_MASK    = 6'h07;
  localparam logic [5:0]  DIV16_MASK   = 6'h0f;
  localparam logic [5:0]  DIV32_MASK   = 6'h1f;
  localparam logic [5:0]  DIV64_MASK   = 6'h3f;

  // Calculation time: 35 machine cycles, 7 us at 20 MHz
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned CALC_MACHINE   = 35;
  localparam int unsigned CALC_TIME_NS   = 7000;
  localparam int unsigned CALC_CYCLES    = CALC_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  CALC_LAST      = 8'(CALC_CYCLES - 1);

endpackage : ed_timer_pkg

// [wave_calc_unit.sv]
`timescale 1ns/1ps
module wave_calc_unit (
  input  wire logic             core_clk_i,     // System clock fc
  input  wire logic             rst_i,          // Synchronous reset
  input  wire logic             start_i,        // Start or restart pulse
  input  wire logic             three_phase_i,  // 1: 3-phase modulation
  input  wire logic [15:0]      amp_i,          // Clamped amplitude
  input  wire logic [15:0]      half_i,         // Mid level for 3-phase
  input  wire logic [2:0][15:0] sine_i,         // Sine data U, V, W
  input  wire logic [2:0]       neg_i,          // Second half of period
  output logic                  busy_o,         // Calculating
  output logic                  done_o,         // One-cycle end pulse
  output logic [2:0][15:0]      res_o           // Phase results
);

  logic [7:0]       cnt;
  logic [15:0]      amp_q;
  logic             three_q;
  logic [2:0][15:0] sine_q;
  logic [2:0]       neg_q;
  logic [2:0][15:0] next_res;

  // Per-phase product and sign handling
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      wire logic [31:0] prod   = sine_q[g] * amp_q;
      wire logic [15:0] scaled = prod[31:16];
      wire logic [15:0] plus   = half_i + {1'b0, scaled[15:1]};
      wire logic [15:0] minus  = half_i - {1'b0, scaled[15:1]};
      assign next_res[g] = !three_q ? scaled : (neg_q[g] ? minus : plus);
    end
  endgenerate

  // Sequencer: a new start aborts and restarts
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      cnt     <= 8'h00;
      amp_q   <= 16'h0000;
      three_q <= 1'b0;
      sine_q  <= '0;
      neg_q   <= 3'h0;
      res_o   <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_o  <= 1'b1;
        cnt     <= ed_timer_pkg::CALC_LAST;
        amp_q   <= amp_i;
        three_q <= three_phase_i;
        sine_q  <= sine_i;
        neg_q   <= neg_i;
      end else if (busy_o) begin
        if (cnt == 8'h00) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          res_o  <= next_res;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end

endmodule : wave_calc_unit

// [angle_wave_gen.sv]
// How it works
// - Period m for 16-n steps, m+1 n steps
// - Low twelve bits hold base period
// - Angle writable live, above 17FH refused
// - Result is amplitude times sine data
// - Amplitude clamped to PWM period limit
// - Position event captures current angle
// - 3-phase result sign inverts at 180
// - Writing one to kick starts calculation
// - Busy flag reads calculation state
// - Bit 1 adds angle-synchronous calculation start
// - Bit 0 picks interrupt source
// - Direction bit: 0 up, 1 down
// - Phase order sets V, W offsets
// - Tick clock fc/8, 16, 32, 64
// - Modulation select: 0 two, 1 three
// - Transfer enable copies results to compares
// - Control bit 0 enables angle timer
// - Period is (m+n/16)x384 ticks
// - Disabling timer stops and clears angle
// - Calculations only while function enabled
// - Calculation takes 35 machine cycles
// - Compare writes blocked during transfer
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module angle_wave_gen (
  input  wire logic        core_clk_i,        // System clock fc, 20 MHz
  input  wire logic        rst_i,             // Synchronous reset
  input  wire logic        psel_i,            // APB select
  input  wire logic        penable_i,         // APB enable
  input  wire logic        pwrite_i,          // APB direction
  input  wire logic [15:0] paddr_i,           // APB byte address
  input  wire logic [31:0] pwdata_i,          // APB write data
  output logic      [31:0] prdata_o,          // APB read data
  output logic             pready_o,          // APB ready
  output logic             pslverr_o,         // APB error, unmapped
  input  wire logic [15:0] pwm_period_limit_i,// PWM period setting
  input  wire logic        position_detect_i, // Position event pulse
  output logic      [15:0] cmp_u_o,           // U compare value
  output logic      [15:0] cmp_v_o,           // V compare value
  output logic      [15:0] cmp_w_o,           // W compare value
  output logic             cmp_load_o,        // Transfer pulse
  output logic             angle_irq_o        // Angle interrupt pulse
);

  // Registers
  logic [7:0]       ctrl_a;
  logic             sync_sel;
  logic             irq_sel;
  logic [15:0]      period;
  logic [8:0]       angle;
  logic [15:0]      voltage_amplitude;
  logic [8:0]       capture;
  logic [2:0][15:0] cmp;
  logic [15:0]      sine_ram [384];

  // Timer state
  logic [5:0]       pre_cnt;
  logic [12:0]      step_cnt;
  logic [3:0]       corr_acc;

  // Calculation unit
  logic             calc_busy;
  logic             calc_done;
  logic [2:0][15:0] calc_res;
  logic [2:0][15:0] sine_rd;
  logic [2:0]       neg_half;
  logic [2:0][8:0]  ph_angle;

  // Control field views
  wire logic       tmr_en    = ctrl_a[ed_timer_pkg::TMR_EN_BIT];
  wire logic       calc_en   = ctrl_a[ed_timer_pkg::CALC_EN_BIT];
  wire logic       xfer_en   = ctrl_a[ed_timer_pkg::XFER_BIT];
  wire logic       mod3      = ctrl_a[ed_timer_pkg::MOD3_BIT];
  wire logic       order     = ctrl_a[ed_timer_pkg::ORDER_BIT];
  wire logic       dir_down  = ctrl_a[ed_timer_pkg::DIR_BIT];
  wire logic [1:0] tck_sel   = ctrl_a[ed_timer_pkg::TCK_LSB +: 2];

  // APB decode
  wire logic [12:0] reg_idx  = paddr_i[14:2];
  wire logic        in_page  = !paddr_i[15];
  wire logic hit_ctrl_a  = in_page && reg_idx == ed_timer_pkg::CTRL_A_IDX;
  wire logic hit_ctrl_b  = in_page && reg_idx == ed_timer_pkg::CTRL_B_IDX;
  wire logic hit_period  = in_page && reg_idx == ed_timer_pkg::PERIOD_IDX;
  wire logic hit_angle   = in_page && reg_idx == ed_timer_pkg::ANGLE_IDX;
  wire logic hit_amp     = in_page && reg_idx == ed_timer_pkg::AMP_IDX;
  wire logic hit_capture = in_page && reg_idx == ed_timer_pkg::CAPTURE_IDX;
  wire logic hit_sine    = in_page && reg_idx == ed_timer_pkg::SINE_WR_IDX;
  wire logic hit_cmp_u   = in_page && reg_idx == ed_timer_pkg::CMP_U_IDX;
  wire logic hit_cmp_v   = in_page && reg_idx == ed_timer_pkg::CMP_V_IDX;
  wire logic hit_cmp_w   = in_page && reg_idx == ed_timer_pkg::CMP_W_IDX;
  wire logic [2:0] hit_cmp = {hit_cmp_w, hit_cmp_v, hit_cmp_u};
  wire logic mapped = hit_ctrl_a | hit_ctrl_b | hit_period | hit_angle |
                      hit_amp | hit_capture | hit_sine | (|hit_cmp);
  wire logic setup  = psel_i && !penable_i;
  wire logic wr_acc = psel_i && penable_i && pready_o && pwrite_i;

  // Write strobes
  wire logic wr_ctrl_a = wr_acc && hit_ctrl_a;
  wire logic wr_ctrl_b = wr_acc && hit_ctrl_b;
  wire logic wr_period = wr_acc && hit_period;
  wire logic wr_amp    = wr_acc && hit_amp;
  wire logic wr_sine   = wr_acc && hit_sine;
  wire logic ang_ok    = pwdata_i[15:0] <= {7'h00, ed_timer_pkg::ANGLE_MAX};
  wire logic wr_angle  = wr_acc && hit_angle && ang_ok;
  wire logic kick = wr_ctrl_b && pwdata_i[ed_timer_pkg::KICK_BIT];
  wire logic tmr_clear = wr_ctrl_a && !pwdata_i[ed_timer_pkg::TMR_EN_BIT];

  // base period, clamped at the minimum
  wire logic [11:0] base_raw = period[ed_timer_pkg::BASE_MSB:0];
  wire logic [11:0] base_m   = (base_raw < ed_timer_pkg::BASE_MIN) ?
                               ed_timer_pkg::BASE_MIN : base_raw;
  wire logic [3:0]  corr_n   = period[ed_timer_pkg::CORR_LSB +: 4];
  // spread n long steps over 16
  wire logic [4:0]  corr_sum = {1'b0, corr_acc} + {1'b0, corr_n};
  wire logic        extra    = corr_sum >= ed_timer_pkg::CORR_GROUP;
  wire logic [12:0] step_end = {1'b0, base_m} - 13'h0001 + {12'h000, extra};

  wire logic [5:0] div_mask = (tck_sel == 2'b00) ? ed_timer_pkg::DIV8_MASK :
                              (tck_sel == 2'b01) ? ed_timer_pkg::DIV16_MASK :
                              (tck_sel == 2'b10) ? ed_timer_pkg::DIV32_MASK :
                                                   ed_timer_pkg::DIV64_MASK;
  wire logic tick     = tmr_en && ((pre_cnt & div_mask) == div_mask);
  // one step per m or m+1 ticks
  wire logic step_adv = tick && (step_cnt == step_end);

  wire logic [8:0] angle_up = (angle == ed_timer_pkg::ANGLE_MAX) ?
                              9'h000 : angle + 9'h001;
  wire logic [8:0] angle_dn = (angle == 9'h000) ?
                              ed_timer_pkg::ANGLE_MAX : angle - 9'h001;
  wire logic [8:0] angle_nx = dir_down ? angle_dn : angle_up;

  wire logic [9:0] off_v = order ? ed_timer_pkg::DEG_240 :
                                   ed_timer_pkg::DEG_120;
  wire logic [9:0] off_w = order ? ed_timer_pkg::DEG_120 :
                                   ed_timer_pkg::DEG_240;
  wire logic [9:0] sum_v = {1'b0, angle} + off_v;
  wire logic [9:0] sum_w = {1'b0, angle} + off_w;
  wire logic [9:0] mod_v = (sum_v >= ed_timer_pkg::ANGLE_STEPS) ?
                           sum_v - ed_timer_pkg::ANGLE_STEPS : sum_v;
  wire logic [9:0] mod_w = (sum_w >= ed_timer_pkg::ANGLE_STEPS) ?
                           sum_w - ed_timer_pkg::ANGLE_STEPS : sum_w;
  assign ph_angle = {mod_w[8:0], mod_v[8:0], angle};

  // Per-phase table lookup and half-period sign
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_lookup
      assign sine_rd[g]  = sine_ram[ph_angle[g]];
      assign neg_half[g] = ph_angle[g] >= ed_timer_pkg::DEG_180;
    end
  endgenerate

  wire logic [15:0] amp_lim = (voltage_amplitude > pwm_period_limit_i) ?
                              pwm_period_limit_i : voltage_amplitude;
  wire logic [15:0] half_lim = {1'b0, pwm_period_limit_i[15:1]};

  wire logic sync_go = sync_sel && (step_adv || wr_angle);
  wire logic calc_start = calc_en && (kick || sync_go);
  wire logic do_xfer = calc_done && calc_en && xfer_en;

  // Read data mux
  wire logic [2:0] rd_sel_cmp = hit_cmp;
  wire logic [15:0] cmp_view =
    rd_sel_cmp[0] ? ((calc_en && !xfer_en) ? calc_res[0] : cmp[0]) :
    rd_sel_cmp[1] ? ((calc_en && !xfer_en) ? calc_res[1] : cmp[1]) :
                    ((calc_en && !xfer_en) ? calc_res[2] : cmp[2]);
  wire logic [7:0] ctrl_b_rd = {4'h0, 1'b0, calc_busy, sync_sel, irq_sel};
  wire logic [31:0] rd_mux =
    hit_ctrl_a  ? {24'h00_0000, ctrl_a} :
    hit_ctrl_b  ? {24'h00_0000, ctrl_b_rd} :
    hit_period  ? {16'h0000, period} :
    hit_angle   ? {23'h00_0000, angle} :
    hit_amp     ? {16'h0000, voltage_amplitude} :
    hit_capture ? {23'h00_0000, capture} :
    (|hit_cmp)  ? {16'h0000, cmp_view} : 32'h0000_0000;

  wave_calc_unit u_calc (
    .core_clk_i    (core_clk_i),
    .rst_i         (rst_i),
    .start_i       (calc_start),
    .three_phase_i (mod3),
    .amp_i         (amp_lim),
    .half_i        (half_lim),
    .sine_i        (sine_rd),
    .neg_i         (neg_half),
    .busy_o        (calc_busy),
    .done_o        (calc_done),
    .res_o         (calc_res)
  );

  // APB answer: ready in the first access cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup && !mapped;
      prdata_o  <= setup ? rd_mux : 32'h0000_0000;
    end
  end

  // Software control registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_a   <= ed_timer_pkg::CTRL_A_RESET;
      sync_sel <= 1'b0;
      irq_sel  <= 1'b0;
      period   <= ed_timer_pkg::PERIOD_RESET;
      voltage_amplitude      <= 16'h0000;
    end else begin
      if (wr_ctrl_a)
        ctrl_a <= pwdata_i[7:0];
      if (wr_ctrl_b) begin
        sync_sel <= pwdata_i[ed_timer_pkg::SYNC_BIT];
        irq_sel  <= pwdata_i[ed_timer_pkg::IRQSEL_BIT];
      end
      if (wr_period)
        period <= pwdata_i[15:0];
      if (wr_amp)
        voltage_amplitude <= pwdata_i[15:0];
    end
  end

  // Prescaler and step counter
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !tmr_en || tmr_clear) begin
      pre_cnt  <= 6'h00;
      step_cnt <= 13'h0000;
      corr_acc <= 4'h0;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
      if (step_adv) begin
        step_cnt <= 13'h0000;
        corr_acc <= corr_sum[3:0];
      end else if (tick) begin
        step_cnt <= step_cnt + 13'h0001;
      end
    end
  end

  // Angle counter; software write wins over stepping
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      angle <= 9'h000;
    end else if (wr_angle) begin
      angle <= pwdata_i[8:0];
    end else if (tmr_clear) begin
      angle <= 9'h000;
    end else if (step_adv) begin
      angle <= angle_nx;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      capture <= 9'h000;
    else if (position_detect_i)
      capture <= angle;
  end

  // Sine table fill at the current angle address
  always_ff @(posedge core_clk_i) begin
    if (wr_sine)
      sine_ram[angle] <= pwdata_i[15:0];
  end

  // Compare registers, interrupt and transfer pulse
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmp         <= '0;
      cmp_load_o  <= 1'b0;
      angle_irq_o <= 1'b0;
    end else begin
      cmp_load_o  <= do_xfer;
      angle_irq_o <= irq_sel ? calc_done : step_adv;
      if (do_xfer)
        cmp <= calc_res;
      else if (wr_acc && !xfer_en) begin
        for (int i = 0; i < 3; i++) begin
          if (hit_cmp[i])
            cmp[i] <= pwdata_i[15:0];
        end
      end
    end
  end

  assign cmp_u_o = cmp[0];
  assign cmp_v_o = cmp[1];
  assign cmp_w_o = cmp[2];

  a_angle_in_range:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    angle <= ed_timer_pkg::ANGLE_MAX)
    else $error("angle count left its range");

  a_angle_wrap_up:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    step_adv && !dir_down && !wr_angle && !tmr_clear &&
    angle == ed_timer_pkg::ANGLE_MAX |=> angle == 9'h000)
    else $error("up count did not wrap to zero");

  a_angle_step_down:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    step_adv && dir_down && !wr_angle && !tmr_clear && angle != 9'h000
    |=> angle == $past(angle) - 9'h001)
    else $error("down count did not decrement");

  a_angle_refused:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_acc && hit_angle && !ang_ok && !step_adv |=> $stable(angle))
    else $error("illegal angle write was taken");

  a_disable_clears:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    tmr_clear |=> angle == 9'h000 && pre_cnt == 6'h00)
    else $error("disable did not clear the angle");

  a_capture_latch:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    position_detect_i |=> capture == $past(angle))
    else $error("capture missed the angle");

  a_busy_after_start:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    calc_start |=> calc_busy [*8])
    else $error("busy dropped too early");

  a_start_needs_enable:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    calc_busy && !$past(calc_busy) |-> $past(calc_en))
    else $error("calculation ran while disabled");

  a_cmp_write_blocked:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_acc && xfer_en && (|hit_cmp) && !do_xfer |=> $stable(cmp))
    else $error("compare write got through");

  a_irq_source:
  assert property (@(posedge core_clk_i) disable iff (rst_i)
    angle_irq_o |-> $past(irq_sel) ? $past(calc_done) : $past(step_adv))
    else $error("interrupt from wrong source");

endmodule : angle_wave_gen

// [pwm_side_model.sv]
`timescale 1ns/1ps
module pwm_side_model (
  input  wire logic        core_clk_i, // System clock
  input  wire logic        rst_i,      // Synchronous reset
  input  wire logic [15:0] limit_i,    // Period setting to present
  input  wire logic        detect_i,   // Request one position event
  input  wire logic [15:0] cmp_u_i,    // U compare from block
  input  wire logic [15:0] cmp_v_i,    // V compare from block
  input  wire logic [15:0] cmp_w_i,    // W compare from block
  input  wire logic        cmp_load_i, // Transfer pulse
  output logic      [15:0] limit_o,    // PWM period setting
  output logic             detect_o,   // Position event pulse
  output logic      [47:0] duty_o,     // Latched U, V, W duties
  output logic      [7:0]  loads_o     // Transfers seen
);
  // Period setting and position pulse leave through one register
  always_ff @(posedge core_clk_i) begin
    limit_o  <= limit_i;
    detect_o <= detect_i & ~rst_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      duty_o  <= '0;
      loads_o <= '0;
    end else if (cmp_load_i) begin
      duty_o  <= {cmp_u_i, cmp_v_i, cmp_w_i};
      loads_o <= loads_o + 8'h01;
    end
  end
endmodule : pwm_side_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic        kind;
    logic [12:0] idx;
    logic [31:0] d;
    logic [47:0] exp;
  } row_s;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        det_req, pos_det, cmp_load, irq;
  logic [15:0] paddr, lim_set, lim, cu, cv, cw;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] duty;
  logic [7:0]  loads;
  int          errors, cmp_count, n, tot, lng;
  row_s        rows [10];

  angle_wave_gen u_dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pwm_period_limit_i(lim),
    .position_detect_i(pos_det), .cmp_u_o(cu), .cmp_v_o(cv),
    .cmp_w_o(cw), .cmp_load_o(cmp_load), .angle_irq_o(irq));

  pwm_side_model u_pwm (.core_clk_i(clk), .rst_i(rst), .limit_i(lim_set),
    .detect_i(det_req), .cmp_u_i(cu), .cmp_v_i(cv), .cmp_w_i(cw),
    .cmp_load_i(cmp_load), .limit_o(lim), .detect_o(pos_det),
    .duty_o(duty), .loads_o(loads));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chkv(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t value %h exp %h", $time, got, exp);
    end
  endtask : chkv

  task automatic chkn(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chkn

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [12:0] idx,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {1'b0, idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      chkn(k, 0);
      conclude();
    end
  endtask : apb

  task automatic wr(input logic [12:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  // Edges until irq (sel 1) or transfer pulse (sel 0)
  task automatic wait_sig(input logic sel, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((sel ? irq : cmp_load) !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      chkn(k, 0);
      conclude();
    end
  endtask : wait_sig

  task automatic do_reset;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  initial begin
    {rst, psel, penable, pwrite, det_req} = '0;
    paddr = '0;
    pwdata = '0;
    lim_set = 16'h0200;
    rows = '{
      '{1'b0, ed_timer_pkg::PERIOD_IDX, 32'h0000_3020, 48'h3020},
      '{1'b0, ed_timer_pkg::ANGLE_IDX, 32'h0000_017f, 48'h017f},
      '{1'b0, ed_timer_pkg::ANGLE_IDX, 32'h0000_0180, 48'h017f},
      '{1'b0, ed_timer_pkg::AMP_IDX, 32'h0000_1234, 48'h1234},
      '{1'b0, ed_timer_pkg::CAPTURE_IDX, 32'h0000_0055, 48'h0000},
      '{1'b0, 13'h1fca, 32'h0000_0077, 48'h0001_0000_0000},
      '{1'b1, 13'h0000, 32'h0000_0006, 48'h0100_0080_0040},
      '{1'b1, 13'h0000, 32'h0000_0046, 48'h0100_0040_0080},
      '{1'b1, 13'h0000, 32'h0000_000e, 48'h0180_0140_00e0},
      '{1'b1, 13'h0000, 32'h0000_004e, 48'h0180_00e0_0140}};
    do_reset();
    for (int i = 0; i < 3; i++) begin
      wr(ed_timer_pkg::ANGLE_IDX, 32'(i * 128));
      wr(ed_timer_pkg::SINE_WR_IDX, 32'h0000_8000 >> i);
    end
    foreach (rows[i]) begin
      if (rows[i].kind == 1'b0) begin
        wr(rows[i].idx, rows[i].d);
        apb(1'b0, rows[i].idx, 32'h0000_0000);
        chkv({15'h0000, er, rd}, rows[i].exp);
      end else begin
        wr(ed_timer_pkg::AMP_IDX, 32'h0000_0400);
        wr(ed_timer_pkg::ANGLE_IDX, 32'h0000_0000);
        wr(ed_timer_pkg::CTRL_A_IDX, rows[i].d);
        wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0008);
        wait_sig(1'b0, n);
        chkn(n, ed_timer_pkg::CALC_CYCLES + 2);
        @(posedge clk);
        chkv(duty, rows[i].exp);
      end
      $display("row %0d done", i);
    end
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0006);
    wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0008);
    apb(1'b0, ed_timer_pkg::CTRL_B_IDX, 32'h0000_0000);
    chkv(rd[2], 48'h0001);
    wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0009);
    wait_sig(1'b0, n);
    chkn(n, ed_timer_pkg::CALC_CYCLES + 2);
    chkv(irq, 48'h0001);
    wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0000);
    apb(1'b0, ed_timer_pkg::CTRL_B_IDX, 32'h0000_0000);
    chkv(rd[2], 48'h0000);
    wr(ed_timer_pkg::CMP_U_IDX, 32'h0000_1111);
    @(posedge clk);
    chkv(cu, 48'h0100);
    n = int'(loads);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_000a);
    wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0008);
    repeat (150) @(posedge clk);
    chkn(int'(loads), n);
    apb(1'b0, ed_timer_pkg::CMP_U_IDX, 32'h0000_0000);
    chkv(rd, 48'h0180);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0000);
    wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0008);
    apb(1'b0, ed_timer_pkg::CTRL_B_IDX, 32'h0000_0000);
    chkv(rd[2], 48'h0000);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0006);
    wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0002);
    wr(ed_timer_pkg::ANGLE_IDX, 32'h0000_0000);
    wait_sig(1'b0, n);
    chkn(n, ed_timer_pkg::CALC_CYCLES + 2);
    wr(ed_timer_pkg::CTRL_B_IDX, 32'h0000_0000);
    $display("calculation tests done");
    wr(ed_timer_pkg::PERIOD_IDX, 32'h0000_0010);
    for (int c = 0; c < 4; c++) begin
      wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0000);
      wr(ed_timer_pkg::CTRL_A_IDX, 32'((c << 4) | 1));
      wait_sig(1'b1, n);
      wait_sig(1'b1, n);
      chkn(n, 128 << c);
    end
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0000);
    wr(ed_timer_pkg::PERIOD_IDX, 32'h0000_8010);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0001);
    wait_sig(1'b1, n);
    tot = 0;
    lng = 0;
    repeat (16) begin
      wait_sig(1'b1, n);
      tot += n;
      lng += (n == 136);
    end
    chkn(tot, 2112);
    chkn(lng, 8);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0000);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0081);
    wait_sig(1'b1, n);
    apb(1'b0, ed_timer_pkg::ANGLE_IDX, 32'h0000_0000);
    chkv(rd, 48'h017f);
    wait_sig(1'b1, n);
    apb(1'b0, ed_timer_pkg::ANGLE_IDX, 32'h0000_0000);
    chkv(rd, 48'h017e);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0001);
    wr(ed_timer_pkg::ANGLE_IDX, 32'h0000_017f);
    wait_sig(1'b1, n);
    apb(1'b0, ed_timer_pkg::ANGLE_IDX, 32'h0000_0000);
    chkv(rd, 48'h0000);
    wr(ed_timer_pkg::CTRL_A_IDX, 32'h0000_0000);
    apb(1'b0, ed_timer_pkg::ANGLE_IDX, 32'h0000_0000);
    chkv(rd, 48'h0000);
    wr(ed_timer_pkg::ANGLE_IDX, 32'h0000_00a5);
    det_req <= 1'b1;
    @(posedge clk);
    det_req <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, ed_timer_pkg::CAPTURE_IDX, 32'h0000_0000);
    chkv(rd, 48'h00a5);
    $display("timer tests done");
    do_reset();
    apb(1'b0, ed_timer_pkg::PERIOD_IDX, 32'h0000_0000);
    chkv(rd, 48'h0010);
    apb(1'b0, ed_timer_pkg::CTRL_A_IDX, 32'h0000_0000);
    chkv({rd, cu}, 48'h0000);
    $display("reset test done");
    conclude();
  end
endmodule : tb_top
